//--- adc_seq_pkg.sv
// shared constants for the converter sequencer: register map, fields, timing
`default_nettype none
package adc_seq_pkg;
  // register offsets on the plain register port
  localparam logic [2:0] ADDR_CTRL0     = 3'h0;
  localparam logic [2:0] ADDR_CTRL1     = 3'h1;
  localparam logic [2:0] ADDR_RES_HIGH  = 3'h2;
  localparam logic [2:0] ADDR_RES_LOW   = 3'h3;
  localparam logic [2:0] ADDR_INT_CTRL  = 3'h4;
  localparam logic [2:0] ADDR_PIN_SHARE = 3'h5;

  // converter_control_0 fields
  localparam int CH_LSB     = 0;
  localparam int CH_MSB     = 3;
  localparam int FMT_BIT    = 4;
  localparam int PWR_BIT    = 5;
  localparam int BUSY_BIT   = 6;
  localparam int START_BIT  = 7;
  // converter_control_1 fields
  localparam int CKS_LSB    = 0;
  localparam int CKS_MSB    = 2;
  localparam int REF_LSB    = 3;
  localparam int REF_MSB    = 4;
  localparam int INS_LSB    = 5;
  localparam int INS_MSB    = 7;
  // interrupt control fields
  localparam int GIE_BIT    = 0;
  localparam int CIE_BIT    = 1;
  localparam int FLAG_BIT   = 2;

  // field codes
  localparam logic [1:0] REF_INTERNAL = 2'h1;
  localparam logic [2:0] INS_BANDGAP  = 3'h1;
  localparam logic [2:0] INS_GND_LO   = 3'h2;
  localparam logic [2:0] INS_GND_HI   = 3'h4;
  localparam logic [3:0] CH_LAST      = 4'h7;
  localparam logic [7:0] RESET_BYTE   = 8'h00;

  // conversion timing in converter clock periods
  localparam logic [3:0] SAMPLE_LAST  = 4'h3;
  localparam logic [3:0] CONVERT_LAST = 4'hf;
  localparam logic [3:0] CONVERT_FIRST = 4'h4;
  localparam logic [11:0] MSB_TRIAL   = 12'h800;

  typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONVERT} seq_state_t;
endpackage : adc_seq_pkg
`default_nettype wire

//--- adc_clock_divider.sv
// converter clock divider: one tick every 2**code system clocks
`default_nettype none
module adc_clock_divider #(
  parameter int DIV_W = 7
) (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       run,
  input  wire logic       restart,
  input  wire logic [2:0] code,
  output logic            tick
);
  logic [DIV_W-1:0] cnt_r;
  logic [DIV_W-1:0] last;

  // code 000 is reserved; it gives a last value of zero and no tick
  assign last = DIV_W'((1 << code) - 1);

  // free count while running, cleared on restart so a period starts clean
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_r <= '0;
    end else if (!run || restart || cnt_r == last) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  assign tick = run && !restart && (code != 3'h0) && (cnt_r == last);
endmodule : adc_clock_divider
`default_nettype wire

//--- adc_result_format.sv
// places the 12-bit result into the high and low result bytes
`default_nettype none
module adc_result_format (
  input  wire logic [11:0] result,
  input  wire logic        right_just,
  output logic      [7:0]  high_byte,
  output logic      [7:0]  low_byte
);
  // unused bits read as zero in either layout
  always_comb begin
    if (right_just) begin
      high_byte = {4'h0, result[11:8]};
      low_byte  = result[7:0];
    end else begin
      high_byte = result[11:4];
      low_byte  = {result[3:0], 4'h0};
    end
  end
endmodule : adc_result_format
`default_nettype wire

//--- adc_conversion_sequencer.sv
// converter sequencer: registers, source muxing, pin overrides, sar timing
// How it works
// - reference from internal analog supply only when reference select is 01
// - a pin chosen as analog input loses all its other functions
// - a pin chosen as analog input has its pull-high switched off
// - a pin chosen as analog input ignores its port direction setting
// - source codes 000 and 101 to 111 connect an external channel
// - code 001 converts bandgap, 010 to 100 converts ground, channel ignored
// - channel codes 0 to 7 pick a pin, 8 to 15 pick nothing
// - an internal source always disconnects the external channel
// - four sampling periods then twelve converting periods, sixteen in all
// - divider codes 1 to 7 give system clock over 2 to 128
// - converter powered only while power enable is set
// - clearing power enable switches converter off and stops it
// - result layout follows the format select bit
// - interrupt reaches cpu only with global and converter enables set
// - a start bit written high then low begins a conversion
// - busy high during conversion, low at end with result ready
// - conversion runs alone, register port never waits
// - result is twelve bits, full scale fff
// - completion sets the request flag and pulses an internal event
`default_nettype none
module adc_conversion_sequencer #(
  parameter int PINS = 8
) (
  input  wire logic            clk,
  input  wire logic            sys_rst,
  input  wire logic [2:0]      addr,
  input  wire logic [7:0]      wdata,
  input  wire logic            wr,
  input  wire logic            rd,
  output logic      [7:0]      rdata_r,
  input  wire logic            comp_hi,
  input  wire logic [PINS-1:0] pullup_cfg,
  input  wire logic [PINS-1:0] drive_cfg,
  output logic                 ref_internal_r,
  output logic                 ext_channel_en_r,
  output logic      [2:0]      ext_channel_idx_r,
  output logic                 bandgap_sel_r,
  output logic                 ground_sel_r,
  output logic                 power_on_r,
  output logic                 sample_r,
  output logic      [11:0]     dac_code_r,
  output logic      [PINS-1:0] pin_analog_r,
  output logic      [PINS-1:0] pin_pullup_en_r,
  output logic      [PINS-1:0] pin_drive_en_r,
  output logic                 irq_r,
  output logic                 irq_event_r
);
  logic [7:0]  ctrl0_r;
  logic [7:0]  ctrl1_r;
  logic [1:0]  int_en_r;
  logic        flag_r;
  logic [PINS-1:0] pin_share_r;
  logic        busy_r;
  logic [3:0]  tick_cnt_r;
  logic [11:0] result_r;
  adc_seq_pkg::seq_state_t state_r;
  logic        start_go;
  logic        done;
  logic        tick;
  logic [7:0]  res_high;
  logic [7:0]  res_low;
  logic [2:0]  ins;
  logic        pwr;

  assign ins = ctrl1_r[adc_seq_pkg::INS_MSB:adc_seq_pkg::INS_LSB];
  assign pwr = ctrl0_r[adc_seq_pkg::PWR_BIT];

  // internal source decode, used by the mux and its check
  function automatic logic is_ground(input logic [2:0] s);
    return s >= adc_seq_pkg::INS_GND_LO && s <= adc_seq_pkg::INS_GND_HI;
  endfunction : is_ground

  function automatic logic is_internal(input logic [2:0] s);
    return s == adc_seq_pkg::INS_BANDGAP || is_ground(s);
  endfunction : is_internal

  // a start bit that was high and is now written low launches a run
  assign start_go = wr && addr == adc_seq_pkg::ADDR_CTRL0 && pwr
                    && ctrl0_r[adc_seq_pkg::START_BIT]
                    && !wdata[adc_seq_pkg::START_BIT];
  assign done = state_r == adc_seq_pkg::ST_CONVERT && tick
                && tick_cnt_r == adc_seq_pkg::CONVERT_LAST;

  adc_clock_divider #(
    .DIV_W(7)
  ) u_div (
    .clk     (clk),
    .sys_rst (sys_rst),
    .run     (busy_r && pwr),
    .restart (start_go),
    .code    (ctrl1_r[adc_seq_pkg::CKS_MSB:adc_seq_pkg::CKS_LSB]),
    .tick    (tick)
  );

  adc_result_format u_fmt (
    .result     (result_r),
    .right_just (ctrl0_r[adc_seq_pkg::FMT_BIT]),
    .high_byte  (res_high),
    .low_byte   (res_low)
  );

  // control registers; the busy bit position is stored from wdata here, but reads return busy_r
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl0_r     <= adc_seq_pkg::RESET_BYTE;
      ctrl1_r     <= adc_seq_pkg::RESET_BYTE;
      int_en_r    <= '0;
      pin_share_r <= '0;
    end else if (wr) begin
      case (addr)
        adc_seq_pkg::ADDR_CTRL0:     ctrl0_r     <= wdata;
        adc_seq_pkg::ADDR_CTRL1:     ctrl1_r     <= wdata;
        adc_seq_pkg::ADDR_INT_CTRL:  int_en_r    <= wdata[adc_seq_pkg::CIE_BIT:0];
        adc_seq_pkg::ADDR_PIN_SHARE: pin_share_r <= wdata[PINS-1:0];
        default: ;
      endcase
    end
  end

  // request flag: completion wins over a software clear in the same cycle
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      flag_r <= 1'b0;
    end else if (done) begin
      flag_r <= 1'b1;
    end else if (wr && addr == adc_seq_pkg::ADDR_INT_CTRL) begin
      flag_r <= wdata[adc_seq_pkg::FLAG_BIT];
    end
  end

  // read data stand the cycle after the strobe; unmapped offsets read zero
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_r <= adc_seq_pkg::RESET_BYTE;
    end else if (rd) begin
      case (addr)
        adc_seq_pkg::ADDR_CTRL0: begin
          rdata_r <= ctrl0_r;
          rdata_r[adc_seq_pkg::BUSY_BIT] <= busy_r;
        end
        adc_seq_pkg::ADDR_CTRL1:     rdata_r <= ctrl1_r;
        adc_seq_pkg::ADDR_RES_HIGH:  rdata_r <= res_high;
        adc_seq_pkg::ADDR_RES_LOW:   rdata_r <= res_low;
        adc_seq_pkg::ADDR_INT_CTRL:  rdata_r <= {5'h0, flag_r, int_en_r};
        adc_seq_pkg::ADDR_PIN_SHARE: rdata_r <= 8'(pin_share_r);
        default:                     rdata_r <= adc_seq_pkg::RESET_BYTE;
      endcase
    end else begin
      rdata_r <= adc_seq_pkg::RESET_BYTE;
    end
  end

  // sequencer: runs on divider ticks so the cpu side is never stalled
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r    <= adc_seq_pkg::ST_IDLE;
      tick_cnt_r <= '0;
      busy_r     <= 1'b0;
    end else if (!pwr) begin
      state_r    <= adc_seq_pkg::ST_IDLE;
      tick_cnt_r <= '0;
      busy_r     <= 1'b0;
    end else if (start_go) begin
      state_r    <= adc_seq_pkg::ST_SAMPLE;
      tick_cnt_r <= '0;
      busy_r     <= 1'b1;
    end else if (tick) begin
      case (state_r)
        adc_seq_pkg::ST_SAMPLE: begin
          tick_cnt_r <= tick_cnt_r + 1'b1;
          if (tick_cnt_r == adc_seq_pkg::SAMPLE_LAST) begin
            state_r <= adc_seq_pkg::ST_CONVERT;
          end
        end
        adc_seq_pkg::ST_CONVERT: begin
          tick_cnt_r <= tick_cnt_r + 1'b1;
          if (tick_cnt_r == adc_seq_pkg::CONVERT_LAST) begin
            state_r    <= adc_seq_pkg::ST_IDLE;
            tick_cnt_r <= '0;
            busy_r     <= 1'b0;
          end
        end
        default: state_r <= adc_seq_pkg::ST_IDLE;
      endcase
    end
  end

  // successive approximation: one bit per converting period, msb first
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dac_code_r <= '0;
    end else if (start_go || !pwr) begin
      dac_code_r <= '0;
    end else if (tick && state_r == adc_seq_pkg::ST_SAMPLE
                 && tick_cnt_r == adc_seq_pkg::SAMPLE_LAST) begin
      dac_code_r <= adc_seq_pkg::MSB_TRIAL;
    end else if (tick && state_r == adc_seq_pkg::ST_CONVERT) begin
      dac_code_r <= sar_step(dac_code_r, tick_cnt_r, comp_hi);
    end
  end

  // keep or drop the trial bit, then set the next lower one
  function automatic logic [11:0] sar_step(input logic [11:0] code,
                                           input logic [3:0] cnt,
                                           input logic keep);
    logic [11:0] mask;
    mask = adc_seq_pkg::MSB_TRIAL >> (cnt - adc_seq_pkg::CONVERT_FIRST);
    return (keep ? code : (code & ~mask)) | (mask >> 1);
  endfunction : sar_step

  // result latched only at the end, so a read mid-run shows the last one
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      result_r <= '0;
    end else if (done) begin
      result_r <= sar_step(dac_code_r, tick_cnt_r, comp_hi);
    end
  end

  // analog controls: reference, source mux, power and sample switch
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ref_internal_r    <= 1'b0;
      ext_channel_en_r  <= 1'b0;
      ext_channel_idx_r <= '0;
      bandgap_sel_r     <= 1'b0;
      ground_sel_r      <= 1'b0;
      power_on_r        <= 1'b0;
      sample_r          <= 1'b0;
    end else begin
      ref_internal_r    <= ctrl1_r[adc_seq_pkg::REF_MSB:adc_seq_pkg::REF_LSB]
                           == adc_seq_pkg::REF_INTERNAL;
      ext_channel_en_r  <= !is_internal(ins)
                           && ctrl0_r[adc_seq_pkg::CH_MSB:adc_seq_pkg::CH_LSB]
                              <= adc_seq_pkg::CH_LAST;
      ext_channel_idx_r <= ctrl0_r[adc_seq_pkg::CH_LSB+2:adc_seq_pkg::CH_LSB];
      bandgap_sel_r     <= ins == adc_seq_pkg::INS_BANDGAP;
      ground_sel_r      <= is_ground(ins);
      power_on_r        <= pwr;
      sample_r          <= state_r == adc_seq_pkg::ST_SAMPLE;
    end
  end

  // pin overrides: analog selection beats pull-high and driver settings
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_analog_r    <= '0;
      pin_pullup_en_r <= '0;
      pin_drive_en_r  <= '0;
    end else begin
      pin_analog_r    <= pin_share_r;
      pin_pullup_en_r <= pullup_cfg & ~pin_share_r;
      pin_drive_en_r  <= drive_cfg & ~pin_share_r;
    end
  end

  // interrupt gating and the one-cycle completion event
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_r       <= 1'b0;
      irq_event_r <= 1'b0;
    end else begin
      irq_r       <= flag_r && int_en_r[adc_seq_pkg::GIE_BIT]
                     && int_en_r[adc_seq_pkg::CIE_BIT];
      irq_event_r <= done;
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_launch;
    start_go;
  endsequence

  sequence s_running;
    busy_r && state_r == adc_seq_pkg::ST_SAMPLE && tick_cnt_r == 4'h0;
  endsequence

  a_start_sets_busy: assert property (s_launch |=> s_running)
    else $error("start did not begin sampling");

  a_done_clears_busy: assert property (done |=> !busy_r && flag_r && irq_event_r)
    else $error("completion did not clear busy and set flag");

  a_sample_length: assert property (state_r == adc_seq_pkg::ST_SAMPLE && tick
      && tick_cnt_r == 4'h3 && pwr && !start_go |=> state_r == adc_seq_pkg::ST_CONVERT)
    else $error("sampling did not last four periods");

  // independent tally of ticks since launch, so the length check does not reuse the sequencer count
  logic [4:0] run_ticks_r;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      run_ticks_r <= '0;
    end else if (start_go || !busy_r) begin
      run_ticks_r <= '0;
    end else if (tick) begin
      run_ticks_r <= run_ticks_r + 1'b1;
    end
  end

  a_done_count: assert property (done |-> run_ticks_r == {1'b0, adc_seq_pkg::CONVERT_LAST})
    else $error("conversion did not last sixteen periods");

  a_irq_gating: assert property (irq_r |-> $past(flag_r) && $past(int_en_r) == 2'h3)
    else $error("interrupt without both enables");

  // power_on_r follows pwr one cycle late, so it is checked in the same cycle as busy
  a_power_off: assert property (!pwr |=> state_r == adc_seq_pkg::ST_IDLE && !busy_r
      && !power_on_r)
    else $error("converter kept running with power off");

  a_ref_select: assert property (ref_internal_r == ($past(ctrl1_r[4:3]) == 2'h1))
    else $error("reference selection wrong");

  a_ext_isolated: assert property ((bandgap_sel_r || ground_sel_r) |-> !ext_channel_en_r)
    else $error("external channel joined to internal source");

  a_pin_override: assert property ((pin_pullup_en_r & $past(pin_share_r)) == '0
      && (pin_drive_en_r & $past(pin_share_r)) == '0)
    else $error("analog pin kept pull-high or driver");
endmodule : adc_conversion_sequencer
`default_nettype wire

//--- adc_conversion_sequencer_tb_top.sv
// self-checking bench for the converter sequencer: sources, pins, timing, results
`default_nettype none
module adc_conversion_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk;
  logic        sys_rst;
  logic [2:0]  addr;
  logic [7:0]  wdata;
  logic        wr;
  logic        rd;
  logic [7:0]  rdata_r;
  logic        comp_hi;
  logic [7:0]  pullup_cfg;
  logic [7:0]  drive_cfg;
  logic        ref_internal_r;
  logic        ext_channel_en_r;
  logic [2:0]  ext_channel_idx_r;
  logic        bandgap_sel_r;
  logic        ground_sel_r;
  logic        power_on_r;
  logic        sample_r;
  logic [11:0] dac_code_r;
  logic [7:0]  pin_analog_r;
  logic [7:0]  pin_pullup_en_r;
  logic [7:0]  pin_drive_en_r;
  logic        irq_r;
  logic        irq_event_r;
  logic [11:0] target;
  int          bad_count;
  int          total_checks;
  int          cycles;

  adc_conversion_sequencer #(.PINS(8)) dut (
    .clk(clk), .sys_rst(sys_rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata_r(rdata_r), .comp_hi(comp_hi), .pullup_cfg(pullup_cfg), .drive_cfg(drive_cfg),
    .ref_internal_r(ref_internal_r), .ext_channel_en_r(ext_channel_en_r),
    .ext_channel_idx_r(ext_channel_idx_r), .bandgap_sel_r(bandgap_sel_r),
    .ground_sel_r(ground_sel_r), .power_on_r(power_on_r), .sample_r(sample_r),
    .dac_code_r(dac_code_r), .pin_analog_r(pin_analog_r),
    .pin_pullup_en_r(pin_pullup_en_r), .pin_drive_en_r(pin_drive_en_r),
    .irq_r(irq_r), .irq_event_r(irq_event_r)
  );

  // ideal comparator: the trial code stays while the input is at or above it
  assign comp_hi = (target >= dac_code_r);

  // 50 MHz system clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // hang guard: well above the roughly 5000 cycles the scenarios need
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      bad_count++;
      give_verdict();
    end
  end

  task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : give_verdict

  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    @(negedge clk);
    d = rdata_r;
  endtask : rd_reg

  // start bit high then low, power kept on, channel 0
  task automatic start_conv(input logic fmt);
    wr_reg(adc_seq_pkg::ADDR_CTRL0, {3'b101, fmt, 4'h0});
    wr_reg(adc_seq_pkg::ADDR_CTRL0, {3'b001, fmt, 4'h0});
  endtask : start_conv

  // length of the next sampling window in system clocks
  task automatic sample_len(output int n);
    int g;
    g = 0;
    n = 0;
    while (sample_r !== 1'b1 && g < 300) begin
      @(negedge clk);
      g++;
    end
    while (sample_r === 1'b1 && n < 1000) begin
      @(negedge clk);
      n++;
    end
  endtask : sample_len

  // cycles until the completion event, giving up at lim
  task automatic wait_done(input int lim, output int n);
    n = 0;
    while (irq_event_r !== 1'b1 && n < lim) begin
      @(negedge clk);
      n++;
    end
  endtask : wait_done

  task automatic reset_state();
    logic [7:0] d;
    check("power after reset", power_on_r, 12'h000);
    check("irq after reset", irq_r, 12'h000);
    rd_reg(adc_seq_pkg::ADDR_CTRL1, d);
    check("control_1 reset", d, 12'h000);
  endtask : reset_state

  // every source code with a real and a missing channel, all reference codes
  task automatic source_select();
    logic [2:0] ins;
    logic [3:0] ch;
    logic       ext;
    for (int i = 0; i < 16; i++) begin
      ins = i[3:1];
      ch  = {i[0], i[3:1]};
      ext = (ins == 3'h0) || (ins >= 3'h5);
      // park on a missing channel before the source moves; the reference pin is never claimed
      wr_reg(adc_seq_pkg::ADDR_CTRL0, 8'h08);
      wr_reg(adc_seq_pkg::ADDR_CTRL1, {ins, i[1:0], 3'h1});
      wr_reg(adc_seq_pkg::ADDR_CTRL0, {4'h0, ch});
      repeat (2) @(negedge clk);
      check("ref internal", ref_internal_r, 12'(i[1:0] == 2'h1));
      check("ext switch", ext_channel_en_r, 12'(ext && !ch[3]));
      if (ext && !ch[3]) begin
        check("ext index", ext_channel_idx_r, 12'(ch[2:0]));
      end
      check("bandgap", bandgap_sel_r, 12'(ins == 3'h1));
      check("ground", ground_sel_r, 12'(ins >= 3'h2 && ins <= 3'h4));
    end
  endtask : source_select

  // analog pins override pull-high and driver, unmapped offset reads zero
  task automatic pin_share();
    logic [7:0] d;
    @(posedge clk);
    pullup_cfg <= 8'hff;
    drive_cfg  <= 8'h3c;
    wr_reg(adc_seq_pkg::ADDR_PIN_SHARE, 8'ha5);
    repeat (2) @(negedge clk);
    check("pin analog", pin_analog_r, 12'h0a5);
    check("pin pullup", pin_pullup_en_r, 12'h05a);
    check("pin drive", pin_drive_en_r, 12'h018);
    wr_reg(3'h6, 8'hff);
    rd_reg(3'h6, d);
    check("unmapped read", d, 12'h000);
  endtask : pin_share

  // one conversion per divider code, both formats, all enable pairs
  task automatic run_conversions();
    int         n;
    logic [7:0] h;
    logic [7:0] l;
    for (int code = 1; code < 8; code++) begin
      target = (code == 7) ? 12'hfff : (12'h5a3 ^ 12'(code));
      wr_reg(adc_seq_pkg::ADDR_INT_CTRL, {6'h00, code[1:0]});
      wr_reg(adc_seq_pkg::ADDR_CTRL1, {5'h01, code[2:0]});
      start_conv(code[0]);
      sample_len(n);
      check("sample clocks", 12'(n), 12'(4 << code));
      check("powered", power_on_r, 12'h001);
      wait_done(5000, n);
      // count runs from the first negedge after sampling to the lagged event: one short
      check("convert clocks", 12'(n), 12'((12 << code) - 1));
      @(negedge clk);
      check("event pulse", irq_event_r, 12'h000);
      @(negedge clk);
      check("irq level", irq_r, 12'(code[1:0] == 2'h3));
      rd_reg(adc_seq_pkg::ADDR_CTRL0, h);
      check("busy clear", h, {4'h0, 3'b001, code[0], 4'h0});
      rd_reg(adc_seq_pkg::ADDR_INT_CTRL, l);
      check("flag set", l, {4'h0, 6'h01, code[1:0]});
      rd_reg(adc_seq_pkg::ADDR_RES_HIGH, h);
      rd_reg(adc_seq_pkg::ADDR_RES_LOW, l);
      if (code[0]) begin
        check("high right", h, {8'h00, target[11:8]});
        check("low right", l, {4'h0, target[7:0]});
      end else begin
        check("high left", h, {4'h0, target[11:4]});
        check("low left", l, {4'h0, target[3:0], 4'h0});
      end
    end
  endtask : run_conversions

  // restart mid-conversion, then power off mid-conversion, then a refused start
  task automatic restart_power_off();
    int         n;
    logic [7:0] d;
    target = 12'h3c7;
    wr_reg(adc_seq_pkg::ADDR_INT_CTRL, 8'h00);
    wr_reg(adc_seq_pkg::ADDR_CTRL1, 8'h01);
    start_conv(1'b0);
    sample_len(n);
    repeat (5) @(posedge clk);
    start_conv(1'b0);
    sample_len(n);
    check("restart sampling", 12'(n), 12'h008);
    wait_done(5000, n);
    check("restart convert", 12'(n), 12'h017);
    // clear the flag left by that completion so the abort check sees only the abort
    wr_reg(adc_seq_pkg::ADDR_INT_CTRL, 8'h00);
    start_conv(1'b0);
    repeat (10) @(posedge clk);
    rd_reg(adc_seq_pkg::ADDR_CTRL0, d);
    check("busy while running", d, 12'h060);
    wr_reg(adc_seq_pkg::ADDR_CTRL0, 8'h00);
    wait_done(60, n);
    check("no completion", 12'(n), 12'd60);
    check("power off", power_on_r, 12'h000);
    check("sampler open", sample_r, 12'h000);
    rd_reg(adc_seq_pkg::ADDR_INT_CTRL, d);
    check("flag after abort", d, 12'h000);
    wr_reg(adc_seq_pkg::ADDR_CTRL0, 8'h80);
    wr_reg(adc_seq_pkg::ADDR_CTRL0, 8'h00);
    repeat (4) @(posedge clk);
    rd_reg(adc_seq_pkg::ADDR_CTRL0, d);
    check("start unpowered", d, 12'h000);
  endtask : restart_power_off

  // reset, then the scenarios in turn
  initial begin
    sys_rst      = 1'b1;
    addr         = 3'h0;
    wdata        = 8'h00;
    wr           = 1'b0;
    rd           = 1'b0;
    pullup_cfg   = 8'h00;
    drive_cfg    = 8'h00;
    target       = 12'h000;
    bad_count    = 0;
    total_checks = 0;
    cycles       = 0;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    @(negedge clk);
    reset_state();
    source_select();
    pin_share();
    run_conversions();
    restart_power_off();
    give_verdict();
  end
endmodule : adc_conversion_sequencer_tb_top
`default_nettype wire
